//--- rpsp_pkg.sv
// Purpose: shared constants and types of the half-duplex serial port
// Assumes: 50 MHz system clock, APB register access
// Notes:   byte addresses are word aligned
package rpsp_pkg;
	localparam int CLK_HZ = 50_000_000;
	// --------------------------------------------------
	// register map
	// --------------------------------------------------
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_PARAM_A = 8'h04;
	localparam logic [7:0] A_PARAM_B = 8'h08;
	localparam logic [7:0] A_TXDATA  = 8'h0C;
	localparam logic [7:0] A_SEND    = 8'h10;
	localparam logic [7:0] A_RXDATA  = 8'h14;
	localparam logic [7:0] A_STATUS  = 8'h18;
	// --------------------------------------------------
	// configuration codes
	// --------------------------------------------------
	localparam logic [2:0] PR_RAW    = 3'h1;
	localparam logic [2:0] PR_DELIM  = 3'h2;
	localparam logic [2:0] PR_BLOCK  = 3'h3;
	localparam logic [2:0] PR_DRIVE  = 3'h4;
	localparam logic [2:0] PR_MB_RTU = 3'h5;
	localparam logic [2:0] PR_MB_ASC = 3'h6;
	localparam logic [1:0] PAR_ODD   = 2'h1;
	localparam logic [1:0] PAR_EVEN  = 2'h2;
	localparam logic [7:0] ID_LIMIT  = 8'h20;
	localparam logic [11:0] MAX_TELEGRAM = 12'h400;
	localparam logic [3:0] CHAR_MIN_BITS = 4'h5;
	// --------------------------------------------------
	// result codes
	// --------------------------------------------------
	localparam logic [15:0] RC_OK       = 16'h0000;
	localparam logic [15:0] RC_ACK_OK   = 16'h2000;
	localparam logic [15:0] RC_BUSY     = 16'h7002;
	localparam logic [15:0] RC_ACK_TMO  = 16'h8090;
	localparam logic [15:0] RC_OVERFLOW = 16'h9000;
	localparam logic [15:0] RC_TOO_LONG = 16'h9001;
	localparam logic [15:0] RC_TOO_SHORT= 16'h9002;
	localparam logic [15:0] RC_NO_CFG   = 16'h809B;
	// --------------------------------------------------
	// types
	// --------------------------------------------------
	typedef struct packed {
		logic [7:0] handshake_setting;
		logic [1:0] stop_code;
		logic [1:0] parity_code;
		logic [1:0] character_length_code;
		logic [7:0] baud_code;
		logic [2:0] protocol;
		logic       point_to_point_mode;
	} rpsp_cfg_s;
	localparam rpsp_cfg_s CFG_RESET = '0;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_LOAD = 2'b01,
		TX_CHAR = 2'b11,
		TX_ACK  = 2'b10
	} rpsp_tx_e;
	// half-bit period in system clocks per baud code
	function automatic logic [15:0] half_div(input logic [7:0] code);
		int rate;
		case (code)
			8'h04:   rate = 1200;
			8'h05:   rate = 1800;
			8'h06:   rate = 2400;
			8'h07:   rate = 4800;
			8'h08:   rate = 7200;
			8'h09:   rate = 9600;
			8'h0A:   rate = 14400;
			8'h0B:   rate = 19200;
			8'h0C:   rate = 38400;
			8'h0D:   rate = 57600;
			8'h0E:   rate = 115200;
			default: rate = 9600;
		endcase
		half_div = 16'(CLK_HZ / (2 * rate));
	endfunction
endpackage

//--- rpsp_port.sv
// Purpose: half-duplex two-wire serial port with framing protocols
// Assumes: pins synchronous to sys_clk_i; APB slave, zero wait states while ce_i is high
// Notes:   one character engine shared by all protocols
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module rpsp_port #(
	parameter int DEPTH = 2048,                  // bytes per FIFO
	parameter int AW    = 11                     // FIFO address width
) (
	input  wire logic        sys_clk_i,          // system clock
	input  wire logic        rst_n_i,            // synchronous reset
	input  wire logic        ce_i,               // clock enable
	input  wire logic        psel_i,             // apb select
	input  wire logic        penable_i,          // apb enable
	input  wire logic        pwrite_i,           // apb direction
	input  wire logic [7:0]  paddr_i,            // apb byte address
	input  wire logic [31:0] pwdata_i,           // apb write data
	output logic      [31:0] prdata_o,           // apb read data
	output logic             pready_o,           // apb ready
	output logic             pslverr_o,          // apb error
	input  wire logic        line_rx_i,          // received line level
	output logic             line_tx_o,          // transmitted line level
	output logic             line_oe_o,          // line driver enable
	output logic             rts_o               // bus direction
);
	// --------------------------------------------------
	// registers and state
	// --------------------------------------------------
	rpsp_pkg::rpsp_cfg_s cfg_ff, nxt_cfg;
	logic [31:0]         param_a_ff, nxt_param_a, param_b_ff, nxt_param_b;
	rpsp_pkg::rpsp_tx_e  tx_st_ff, nxt_tx_st;
	logic [7:0]  tx_mem [DEPTH];
	logic [7:0]  rx_mem [DEPTH];
	logic [AW-1:0] tx_wr_ff, nxt_tx_wr, tx_rd_ff, nxt_tx_rd, tx_cur_ff, nxt_tx_cur;
	logic [AW-1:0] rx_wr_ff, nxt_rx_wr, rx_rd_ff, nxt_rx_rd;
	logic [AW:0]   tx_cnt_ff, nxt_tx_cnt, rx_cnt_ff, nxt_rx_cnt;
	logic [11:0] len_ff, nxt_len, rem_ff, nxt_rem;
	logic [2:0]  ph_ff, nxt_ph;
	logic [7:0]  try_ff, nxt_try;
	logic [4:0]  thc_ff, nxt_thc, rhc_ff, nxt_rhc;
	logic [15:0] tdiv_ff, nxt_tdiv, rdiv_ff, nxt_rdiv, bdiv_ff, nxt_bdiv;
	logic [15:0] tmo_ff, nxt_tmo, gap_ff, nxt_gap, result_ff, nxt_result;
	logic        rx_busy_ff, nxt_rx_busy, got_ff, nxt_got, partner_ff, nxt_partner;
	logic        seen_ff, nxt_seen, rx_end_ff, nxt_rx_end;
	logic        perr_ff, nxt_perr, rovf_ff, nxt_rovf;
	logic [7:0]  rsh_ff, nxt_rsh, txd_ff, nxt_txd;
	logic        line_ff, nxt_line;
	// --------------------------------------------------
	// derived values
	// --------------------------------------------------
	logic        wr_acc, rd_acc, push_tx, push_rx, pop_rx, commit, hit;
	logic [15:0] hdiv, ack_lim;
	logic [3:0]  nbits;
	logic [4:0]  thalves, tbi, rbi;
	logic [7:0]  id_sel, limit, rx_byte;
	logic        framed, acked, par_bit, t_half, r_half, b_tick, rx_evt;

	assign wr_acc  = psel_i & penable_i & pwrite_i & ce_i;
	assign rd_acc  = psel_i & penable_i & ~pwrite_i & ce_i;
	assign hdiv    = rpsp_pkg::half_div(cfg_ff.baud_code);
	assign nbits   = rpsp_pkg::CHAR_MIN_BITS + {2'b00, cfg_ff.character_length_code};
	// start + data + parity bit in halves, then stop halves 2/3/4
	assign thalves = 5'({nbits, 1'b0}) + 5'h4 + 5'({3'b000, cfg_ff.stop_code}) + 5'h1;
	assign framed  = cfg_ff.protocol != rpsp_pkg::PR_RAW;
	assign acked   = cfg_ff.protocol >= rpsp_pkg::PR_BLOCK &&
	                 cfg_ff.protocol <= rpsp_pkg::PR_MB_ASC;
	// block mode uses word 6, drive and Modbus word 0
	assign ack_lim = (cfg_ff.protocol == rpsp_pkg::PR_BLOCK) ?
	                 param_b_ff[31:16] : param_a_ff[15:0];
	// before the partner ever answered, failures count as connect tries
	assign limit   = (cfg_ff.protocol != rpsp_pkg::PR_BLOCK) ? 8'h00 :
	                 partner_ff ? param_a_ff[23:16] : param_a_ff[15:8];
	assign t_half  = tdiv_ff == hdiv - 16'h1;
	assign r_half  = rdiv_ff == hdiv - 16'h1;
	assign b_tick  = bdiv_ff == {hdiv[14:0], 1'b0} - 16'h1;
	// bit index shown on the pin after this edge, so line and enable move together
	assign tbi     = (thc_ff + 5'(t_half)) >> 1;
	assign rbi     = (rhc_ff + 5'h1) >> 1;
	assign rx_byte = rsh_ff >> (4'h8 - nbits);
	assign par_bit = (cfg_ff.parity_code == rpsp_pkg::PAR_ODD)  ? ~^txd_ff :
	                 (cfg_ff.parity_code == rpsp_pkg::PAR_EVEN) ?  ^txd_ff :
	                 1'b1;
	assign rx_evt  = push_rx;
	assign pop_rx  = rd_acc && paddr_i == rpsp_pkg::A_RXDATA && rx_cnt_ff != '0;
	assign push_tx = wr_acc && paddr_i == rpsp_pkg::A_TXDATA &&
	                 tx_cnt_ff != (AW+1)'(DEPTH);

	always_comb begin
		case (ph_ff)
			3'h0:    id_sel = param_a_ff[7:0];
			3'h1:    id_sel = param_a_ff[15:8];
			3'h3:    id_sel = param_a_ff[23:16];
			default: id_sel = param_a_ff[31:24];
		endcase
	end

	// --------------------------------------------------
	// apb slave
	// --------------------------------------------------
	always_comb begin
		hit = 1'b1;
		case (paddr_i)
			rpsp_pkg::A_CTRL:    prdata_o = 32'(cfg_ff);
			rpsp_pkg::A_PARAM_A: prdata_o = param_a_ff;
			rpsp_pkg::A_PARAM_B: prdata_o = param_b_ff;
			rpsp_pkg::A_TXDATA:  prdata_o = 32'(tx_cnt_ff);
			rpsp_pkg::A_SEND:    prdata_o = 32'(len_ff);
			rpsp_pkg::A_RXDATA:  prdata_o = (rx_cnt_ff != '0) ? {24'h0, rx_mem[rx_rd_ff]} : 32'h0;
			rpsp_pkg::A_STATUS:  prdata_o = {10'h0, rovf_ff, rx_end_ff, perr_ff,
			                                 tx_cnt_ff == (AW+1)'(DEPTH), rx_cnt_ff != '0,
			                                 tx_st_ff != rpsp_pkg::TX_IDLE, result_ff};
			default: begin
				prdata_o = 32'h0;
				hit      = 1'b0;
			end
		endcase
	end
	assign pready_o  = ce_i;
	assign pslverr_o = psel_i & penable_i & ~hit;

	// --------------------------------------------------
	// pins
	// --------------------------------------------------
	// the driver is on only while sending so the partner may answer
	assign line_oe_o = tx_st_ff == rpsp_pkg::TX_CHAR;
	assign rts_o     = line_oe_o;
	assign line_tx_o = line_ff;

	// --------------------------------------------------
	// fifo storage
	// --------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (ce_i && push_tx) begin
			tx_mem[tx_wr_ff] <= pwdata_i[7:0];
		end
		if (ce_i && push_rx) begin
			rx_mem[rx_wr_ff] <= rx_byte;
		end
	end

	// --------------------------------------------------
	// next state
	// --------------------------------------------------
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_param_a = param_a_ff;
		nxt_param_b = param_b_ff;
		nxt_tx_st = tx_st_ff;
		nxt_tx_wr = tx_wr_ff + AW'(push_tx);
		nxt_tx_rd = tx_rd_ff;
		nxt_tx_cur = tx_cur_ff;
		nxt_rx_wr = rx_wr_ff;
		nxt_rx_rd = rx_rd_ff + AW'(pop_rx);
		nxt_len = len_ff;
		nxt_rem = rem_ff;
		nxt_ph = ph_ff;
		nxt_try = try_ff;
		nxt_thc = thc_ff;
		nxt_rhc = rhc_ff;
		nxt_tdiv = t_half ? 16'h0 : tdiv_ff + 16'h1;
		nxt_rdiv = r_half ? 16'h0 : rdiv_ff + 16'h1;
		nxt_bdiv = b_tick ? 16'h0 : bdiv_ff + 16'h1;
		nxt_tmo = tmo_ff;
		nxt_gap = (b_tick && gap_ff != 16'hFFFF) ? gap_ff + 16'h1 : gap_ff;
		nxt_result = result_ff;
		nxt_rx_busy = rx_busy_ff;
		nxt_got = got_ff;
		nxt_partner = partner_ff;
		nxt_seen = seen_ff;
		nxt_rx_end = rx_end_ff;
		nxt_perr = perr_ff;
		nxt_rovf = rovf_ff;
		nxt_rsh = rsh_ff;
		nxt_txd = txd_ff;
		nxt_line = 1'b1;
		push_rx = 1'b0;
		commit = 1'b0;
		// sticky flags clear on status read; a new event in that cycle wins below
		if (rd_acc && paddr_i == rpsp_pkg::A_STATUS) begin
			nxt_perr = 1'b0;
			nxt_rovf = 1'b0;
		end
		if (wr_acc) begin
			case (paddr_i)
				rpsp_pkg::A_CTRL: begin
					// handshake field is stored but steers nothing
					nxt_cfg = rpsp_pkg::rpsp_cfg_s'(pwdata_i[25:0]);
				end
				rpsp_pkg::A_PARAM_A: nxt_param_a = pwdata_i;
				rpsp_pkg::A_PARAM_B: nxt_param_b = pwdata_i;
				rpsp_pkg::A_SEND: begin
					if (!cfg_ff.point_to_point_mode) begin
						nxt_result = rpsp_pkg::RC_NO_CFG;
					end else if (tx_st_ff != rpsp_pkg::TX_IDLE) begin
						nxt_result = rpsp_pkg::RC_BUSY;
					end else if (pwdata_i[11:0] == 12'h0) begin
						nxt_result = rpsp_pkg::RC_TOO_SHORT;
					end else if (framed && (pwdata_i[31:12] != '0 ||
					             pwdata_i[11:0] > rpsp_pkg::MAX_TELEGRAM)) begin
						nxt_result = rpsp_pkg::RC_TOO_LONG;
					end else if (pwdata_i[31:12] != '0 ||
					             13'(pwdata_i[11:0]) > 13'(tx_cnt_ff)) begin
						nxt_result = rpsp_pkg::RC_OVERFLOW;
					end else begin
						nxt_len = pwdata_i[11:0];
						nxt_rem = pwdata_i[11:0];
						nxt_tx_cur = tx_rd_ff;
						nxt_ph = 3'h0;
						nxt_try = 8'h0;
						nxt_tx_st = rpsp_pkg::TX_LOAD;
					end
				end
				default: ;
			endcase
		end
		// transmitter
		case (tx_st_ff)
			rpsp_pkg::TX_IDLE: ;
			rpsp_pkg::TX_LOAD: begin
				nxt_thc = 5'h0;
				nxt_tdiv = 16'h0;
				if (ph_ff == 3'h5) begin
					if (acked) begin
						nxt_tmo = 16'h0;
						nxt_got = 1'b0;
						nxt_tx_st = rpsp_pkg::TX_ACK;
					end else begin
						commit = 1'b1;
						nxt_result = rpsp_pkg::RC_OK;
						nxt_tx_st = rpsp_pkg::TX_IDLE;
					end
				end else if (ph_ff == 3'h2) begin
					if (rem_ff == 12'h0) begin
						nxt_ph = 3'h3;
					end else begin
						nxt_txd = tx_mem[tx_cur_ff];
						nxt_tx_cur = tx_cur_ff + AW'(1);
						nxt_rem = rem_ff - 12'h1;
						nxt_tx_st = rpsp_pkg::TX_CHAR;
					end
				end else begin
					nxt_ph = ph_ff + 3'h1;
					// identifiers frame only delimited telegrams
					if (cfg_ff.protocol == rpsp_pkg::PR_DELIM &&
					    id_sel < rpsp_pkg::ID_LIMIT) begin
						nxt_txd = id_sel;
						nxt_tx_st = rpsp_pkg::TX_CHAR;
					end
				end
				if (nxt_tx_st == rpsp_pkg::TX_CHAR) begin
					nxt_txd = nxt_txd & ~(8'hFF << nbits);
					// start bit leaves with the driver enable, no high glitch first
					nxt_line = 1'b0;
				end
			end
			rpsp_pkg::TX_CHAR: begin
				if (tbi == 5'h0) begin
					nxt_line = 1'b0;
				end else if (tbi <= 5'(nbits)) begin
					nxt_line = txd_ff[3'(tbi - 5'h1)];
				end else if (tbi == 5'(nbits) + 5'h1) begin
					nxt_line = par_bit;
				end
				if (t_half) begin
					nxt_thc = thc_ff + 5'h1;
					if (thc_ff == thalves - 5'h1) begin
						nxt_tx_st = rpsp_pkg::TX_LOAD;
					end
				end
			end
			rpsp_pkg::TX_ACK: begin
				if (b_tick) begin
					nxt_tmo = tmo_ff + 16'h1;
				end
				if (rx_evt) begin
					nxt_got = 1'b1;
					nxt_partner = 1'b1;
				end
				if (got_ff && (cfg_ff.protocol != rpsp_pkg::PR_BLOCK ||
				               gap_ff >= param_b_ff[15:0])) begin
					commit = 1'b1;
					nxt_result = rpsp_pkg::RC_ACK_OK;
					nxt_tx_st = rpsp_pkg::TX_IDLE;
				end else if (!got_ff && tmo_ff >= ack_lim) begin
					if (try_ff < limit) begin
						nxt_try = try_ff + 8'h1;
						nxt_tx_cur = tx_rd_ff;
						nxt_rem = len_ff;
						nxt_ph = 3'h0;
						nxt_tx_st = rpsp_pkg::TX_LOAD;
					end else begin
						commit = 1'b1;
						nxt_result = rpsp_pkg::RC_ACK_TMO;
						nxt_tx_st = rpsp_pkg::TX_IDLE;
					end
				end
			end
			default: nxt_tx_st = rpsp_pkg::TX_IDLE;
		endcase
		if (commit) begin
			nxt_tx_rd = tx_rd_ff + AW'(len_ff);
		end
		nxt_tx_cnt = tx_cnt_ff + (AW+1)'(push_tx) - (commit ? (AW+1)'(len_ff) : '0);
		// receiver, deaf while our own driver is on
		if (!rx_busy_ff) begin
			if (cfg_ff.point_to_point_mode && !line_oe_o && !line_rx_i) begin
				nxt_rx_busy = 1'b1;
				nxt_rhc = 5'h0;
				nxt_rdiv = 16'h0;
			end
		end else if (r_half) begin
			nxt_rhc = rhc_ff + 5'h1;
			if (!rhc_ff[0]) begin
				if (rbi == 5'h0) begin
					nxt_rx_busy = !line_rx_i ? 1'b1 : 1'b0;           // false start
					nxt_rsh = 8'h0;
				end else if (rbi <= 5'(nbits)) begin
					nxt_rsh = {line_rx_i, rsh_ff[7:1]};
				end else if (rbi == 5'(nbits) + 5'h1) begin
					if ((cfg_ff.parity_code == rpsp_pkg::PAR_ODD &&
					     !(^{rx_byte, line_rx_i})) ||
					    (cfg_ff.parity_code == rpsp_pkg::PAR_EVEN &&
					     (^{rx_byte, line_rx_i}))) begin
						nxt_perr = 1'b1;
					end
				end else begin
					nxt_rx_busy = 1'b0;
					push_rx = rx_cnt_ff != (AW+1)'(DEPTH);
					nxt_rovf = nxt_rovf | ~push_rx;
					nxt_gap = 16'h0;
					nxt_seen = 1'b1;
					nxt_rx_end = 1'b0;
				end
			end
		end
		// telegram end after the idle gap of word 4
		if (cfg_ff.protocol == rpsp_pkg::PR_DELIM && seen_ff && !push_rx &&
		    gap_ff >= param_b_ff[15:0]) begin
			nxt_rx_end = 1'b1;
			nxt_seen = 1'b0;
		end
		nxt_rx_wr = rx_wr_ff + AW'(push_rx);
		nxt_rx_cnt = rx_cnt_ff + (AW+1)'(push_rx) - (AW+1)'(pop_rx);
		if (!cfg_ff.point_to_point_mode) begin
			nxt_tx_st = rpsp_pkg::TX_IDLE;
			nxt_rx_busy = 1'b0;
			// a cut character must not leave the pin low
			nxt_line = 1'b1;
		end
	end

	// --------------------------------------------------
	// state registers
	// --------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cfg_ff <= rpsp_pkg::CFG_RESET;
			param_a_ff <= 32'h0;
			param_b_ff <= 32'h0;
			tx_st_ff <= rpsp_pkg::TX_IDLE;
			{tx_wr_ff, tx_rd_ff, tx_cur_ff, rx_wr_ff, rx_rd_ff} <= '0;
			{tx_cnt_ff, rx_cnt_ff, len_ff, rem_ff, ph_ff, try_ff} <= '0;
			{thc_ff, rhc_ff, tdiv_ff, rdiv_ff, bdiv_ff, tmo_ff, gap_ff} <= '0;
			result_ff <= rpsp_pkg::RC_OK;
			{rx_busy_ff, got_ff, partner_ff, seen_ff, rx_end_ff} <= '0;
			{perr_ff, rovf_ff, rsh_ff, txd_ff} <= '0;
			line_ff <= 1'b1;
		end else if (ce_i) begin
			cfg_ff <= nxt_cfg;
			param_a_ff <= nxt_param_a;
			param_b_ff <= nxt_param_b;
			tx_st_ff <= nxt_tx_st;
			{tx_wr_ff, tx_rd_ff, tx_cur_ff, rx_wr_ff, rx_rd_ff} <=
				{nxt_tx_wr, nxt_tx_rd, nxt_tx_cur, nxt_rx_wr, nxt_rx_rd};
			{tx_cnt_ff, rx_cnt_ff, len_ff, rem_ff, ph_ff, try_ff} <=
				{nxt_tx_cnt, nxt_rx_cnt, nxt_len, nxt_rem, nxt_ph, nxt_try};
			{thc_ff, rhc_ff, tdiv_ff, rdiv_ff, bdiv_ff, tmo_ff, gap_ff} <=
				{nxt_thc, nxt_rhc, nxt_tdiv, nxt_rdiv, nxt_bdiv, nxt_tmo, nxt_gap};
			result_ff <= nxt_result;
			{rx_busy_ff, got_ff, partner_ff, seen_ff, rx_end_ff} <=
				{nxt_rx_busy, nxt_got, nxt_partner, nxt_seen, nxt_rx_end};
			{perr_ff, rovf_ff, rsh_ff, txd_ff} <= {nxt_perr, nxt_rovf, nxt_rsh, nxt_txd};
			line_ff <= nxt_line;
		end
	end
endmodule

//--- rpsp_port_sva.sv
// Purpose: port checks of the serial port
// Assumes: control writes are seen on apb
// Notes:   bit length checked at code 0Eh only
`timescale 1ns/100ps
module rpsp_port_sva (
	input wire logic        sys_clk_i, // clock
	input wire logic        rst_n_i,   // reset
	input wire logic        ce_i,      // enable
	input wire logic        psel_i,    // select
	input wire logic        penable_i, // access
	input wire logic        pwrite_i,  // write
	input wire logic [7:0]  paddr_i,   // address
	input wire logic [31:0] pwdata_i,  // wdata
	input wire logic        pready_o,  // ready
	input wire logic        pslverr_o, // error
	input wire logic        line_tx_o, // line
	input wire logic        line_oe_o, // driver
	input wire logic        rts_o      // direction
);
	localparam logic [15:0] BIT_CLKS = 16'h01B2;
	logic        en_ff, nxt_en;
	logic [7:0]  baud_ff, nxt_baud;
	logic [15:0] cnt_ff, nxt_cnt;
	logic        ctl_wr;
	assign ctl_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == rpsp_pkg::A_CTRL;
	always_comb begin
		nxt_en   = ctl_wr ? pwdata_i[0] : en_ff;
		nxt_baud = ctl_wr ? pwdata_i[11:4] : baud_ff;
		// saturates so a long character cannot wrap into the start window
		nxt_cnt  = line_oe_o ? cnt_ff + {15'h0, ~&cnt_ff} : 16'h0;
		if (!rst_n_i) begin
			nxt_en   = 1'b0;
			nxt_baud = 8'h00;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		en_ff   <= nxt_en;
		baud_ff <= nxt_baud;
		cnt_ff  <= nxt_cnt;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence acc_s;
		psel_i && penable_i;
	endsequence
	sequence launch_s;
		!line_oe_o ##1 line_oe_o;
	endsequence
	idle_rst_a: assert property (disable iff (1'b0) !rst_n_i |=> line_tx_o && !line_oe_o)
		else $error("line busy after reset");
	port_off_a: assert property (!en_ff && !line_oe_o |=> !line_oe_o)
		else $error("sending while port off");
	rts_dir_a: assert property (rts_o == line_oe_o)
		else $error("direction differs from driver");
	idle_high_a: assert property (!line_oe_o |-> line_tx_o)
		else $error("line low while released");
	start_low_a: assert property (launch_s |-> !line_tx_o)
		else $error("no start bit");
	start_len_a: assert property (line_oe_o && baud_ff == 8'h0E && cnt_ff < BIT_CLKS |-> !line_tx_o)
		else $error("start bit too short");
	stop_high_a: assert property ($fell(line_oe_o) |-> $past(line_tx_o))
		else $error("no stop level");
	slv_err_a: assert property (acc_s |-> pslverr_o == (paddr_i > rpsp_pkg::A_STATUS || |paddr_i[1:0]))
		else $error("error response wrong");
	ready_ce_a: assert property (pready_o == ce_i)
		else $error("ready wrong");
endmodule

bind rpsp_port rpsp_port_sva u_sva (
	.sys_clk_i, .rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
	.pready_o, .pslverr_o, .line_tx_o, .line_oe_o, .rts_o
);

//--- rpsp_station.sv
// Purpose: remote station on the pair
// Assumes: pair biased high when released
// Notes:   bit period fixed to code 0Eh
`timescale 1ns/100ps
module rpsp_station #(
	parameter int BIT = 434                 // clocks per bit
) (
	input  wire logic       clk_i,   // clock
	input  wire logic       line_i,  // pair level
	input  wire logic [3:0] nbits_i, // data bits
	output logic            tx_o,    // level
	output logic            oe_o     // driving
);
	logic [8:0] rxq[$];
	logic [8:0] cap;
	initial begin
		tx_o = 1'b1;
		oe_o = 1'b0;
		forever begin
			@(negedge line_i);
			if (!oe_o) begin
				repeat (BIT / 2) @(posedge clk_i);
				cap = 9'h000;
				for (int i = 0; i <= nbits_i; i++) begin
					repeat (BIT) @(posedge clk_i);
					cap[i] = line_i;
				end
				rxq.push_back(cap);
			end
		end
	end
	task automatic send_char(input logic [7:0] d, input logic [3:0] n, input logic p);
		oe_o <= 1'b1;
		tx_o <= 1'b0;
		repeat (BIT) @(posedge clk_i);
		for (int i = 0; i <= n; i++) begin
			tx_o <= (i == n) ? p : d[i];
			repeat (BIT) @(posedge clk_i);
		end
		tx_o <= 1'b1;
		repeat (BIT) @(posedge clk_i);
		oe_o <= 1'b0;
	endtask
endmodule

//--- tb.sv
// Purpose: self-checking bench of the serial port
// Assumes: baud code 0Eh, station model on the pair
// Notes:   one telegram byte per scenario, fixed seed
`timescale 1ns/100ps
module tb;
	logic        clk = 1'b0, rst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, d;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, serr, tx, oe, rts, st_tx, st_oe, pair_lv;
	logic [3:0]  nb = 4'h8;
	int          errors = 0, check_count = 0, hi_cnt = 0, h0;
	assign pair_lv = oe ? tx : (st_oe ? st_tx : 1'b1);
	rpsp_port dut (
		.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .line_rx_i(pair_lv),
		.line_tx_o(tx), .line_oe_o(oe), .rts_o(rts)
	);
	rpsp_station st (.clk_i(clk), .line_i(pair_lv), .nbits_i(nb), .tx_o(st_tx), .oe_o(st_oe));
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (oe) hi_cnt <= hi_cnt + 1;
	function automatic logic [31:0] cfg(input logic [2:0] pr, input logic [1:0] ln, pa, sp);
		return {6'h00, 8'h01, sp, pa, ln, 8'h0E, pr, 1'b1};
	endfunction
	function automatic logic [8:0] frame(input logic [7:0] v, input logic [3:0] n, logic [1:0] pa);
		logic [8:0] f;
		f = {1'b0, v} & ((9'h001 << n) - 9'h001);
		f[n] = (pa == 2'h0) ? 1'b1 : ((^f) ^ (pa == rpsp_pkg::PAR_ODD));
		return f;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= v;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// --------------------------------------------
	// one telegram: push, start, wait, result
	// --------------------------------------------
	task automatic run(input logic [31:0] c, input logic [11:0] n, input logic [15:0] rc);
		apb(1'b1, rpsp_pkg::A_CTRL, c);
		apb(1'b1, rpsp_pkg::A_TXDATA, {24'h0, d});
		apb(1'b1, rpsp_pkg::A_SEND, {20'h0, n});
		do apb(1'b0, rpsp_pkg::A_STATUS, 32'h0); while (rdat[16]);
		chk(rdat[15:0], rc);
	endtask
	task automatic finish_test();
		if (errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (95000) @(posedge clk);
		errors++;
		finish_test();
	end
	initial begin
		void'($urandom(22705));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b1, rpsp_pkg::A_SEND, 32'h1);
		apb(1'b0, rpsp_pkg::A_STATUS, 32'h0);
		chk(rdat[15:0], rpsp_pkg::RC_NO_CFG);
		apb(1'b0, 8'h1C, 32'h0);
		chk(16'(serr), 16'h0001);
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			nb = 4'(i % 4 + 5);
			h0 = hi_cnt;
			run(cfg(rpsp_pkg::PR_RAW, 2'(i % 4), 2'(i % 3), 2'(i % 3 + 1)), 12'h1, 16'h0);
			h0 = hi_cnt - h0 - (2 * (nb + 2) + i % 3 + 2) * 217;
			chk(16'(h0 > -4 && h0 < 4), 16'h0001);
			chk(16'(st.rxq.pop_front()), 16'(frame(d, nb, 2'(i % 3))));
		end
		for (int i = 0; i < 2; i++) begin
			d = 8'($urandom);
			apb(1'b1, rpsp_pkg::A_CTRL, cfg(rpsp_pkg::PR_RAW, 2'h3, 2'(i * 2), 2'h1));
			st.send_char(d, 4'h8, i[0] ? ^d : 1'b0);
			apb(1'b0, rpsp_pkg::A_STATUS, 32'h0);
			chk(16'(rdat[19:17]), 16'h0001);
			apb(1'b0, rpsp_pkg::A_RXDATA, 32'h0);
			chk(16'(rdat[7:0]), 16'(d));
		end
		nb = 4'h8;
		// unused slots hold FFh; 20h sits just past the valid range
		apb(1'b1, rpsp_pkg::A_PARAM_A, 32'h20_03_FF_02);
		apb(1'b1, rpsp_pkg::A_PARAM_B, 32'h0000_0010);
		run(cfg(rpsp_pkg::PR_DELIM, 2'h3, 2'h0, 2'h1), 12'h1, 16'h0);
		chk(16'(st.rxq.size()), 16'h0003);
		chk(16'(st.rxq.pop_front()), 16'h0102);
		chk(16'(st.rxq.pop_front()), {8'h01, d});
		chk(16'(st.rxq.pop_front()), 16'h0103);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, rpsp_pkg::A_SEND, 32'(12'h3FF + i));
			apb(1'b0, rpsp_pkg::A_STATUS, 32'h0);
			chk(rdat[15:0], i == 2 ? rpsp_pkg::RC_TOO_LONG : rpsp_pkg::RC_OVERFLOW);
		end
		apb(1'b1, rpsp_pkg::A_PARAM_A, 32'h0000_0003);
		run(cfg(rpsp_pkg::PR_MB_RTU, 2'h3, 2'h2, 2'h1), 12'h1, rpsp_pkg::RC_ACK_TMO);
		st.rxq.delete();
		// priority 55h differs from the silent partner; one connect retry allowed
		apb(1'b1, rpsp_pkg::A_PARAM_A, 32'h0000_0155);
		apb(1'b1, rpsp_pkg::A_PARAM_B, 32'h0002_0004);
		run(cfg(rpsp_pkg::PR_BLOCK, 2'h3, 2'h2, 2'h1), 12'h1, rpsp_pkg::RC_ACK_TMO);
		chk(16'(st.rxq.size()), 16'h0002);
		st.rxq.delete();
		apb(1'b1, rpsp_pkg::A_PARAM_A, 32'h0000_0040);
		fork
			run(cfg(rpsp_pkg::PR_DRIVE, 2'h3, 2'h2, 2'h1), 12'h1, rpsp_pkg::RC_ACK_OK);
			begin
				while (st.rxq.size() == 0) @(posedge clk);
				while (oe) @(posedge clk);
				st.send_char(8'h5A, 4'h8, 1'b0);
			end
		join
		finish_test();
	end
endmodule
